// ===== design/srcd_top.sv
// serial command byte decoder: link shifter on ser_clk, command outputs on core_clk
`timescale 1ns/1ps
module srcd_top
  import srcd_pkg::*;
#(
  parameter int RD_W = DATA_W
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic ser_clk,
  input wire logic ser_cs_n,
  input wire logic ser_din,
  output logic ser_dout,
  output logic ser_dout_oe,
  output logic [5:0] lnk_rd_addr,
  input wire logic [RD_W-1:0] lnk_rd_data,
  output logic [7:0] command_selector,
  output srcd_cmd_t cmd_out,
  output logic cmd_pulse,
  output srcd_wr_t wr_out,
  output logic wr_pulse
);

  // ---------------- link domain (ser_clk) ----------------
  logic lnk_rst;
  srcd_lnk_state_t lnk_state_ff;
  logic [2:0] bit_cnt_ff;
  logic [7:0] shift_ff;
  logic [1:0] left_ff;
  logic first_ff;
  logic read_ff;
  logic [5:0] lnk_addr_ff;
  logic [7:0] lnk_cmd_byte_ff;
  logic cmd_tgl_ff;
  srcd_wr_t lnk_wr_ff;
  logic wr_tgl_ff;
  logic [RD_W-2:0] dout_sh_ff;
  logic dout_ff;
  logic dout_oe_ff;

  logic [7:0] nxt_byte;
  logic byte_done;
  logic cmd_accept;
  logic wr_accept;
  srcd_target_t nxt_target;
  srcd_target_t lnk_target;
  logic [RD_W-1:0] rd_aligned;

  // core reset reaches the link side as a level
  srcd_sync #(.W(1)) u_rst_sync (
    .clk(ser_clk),
    .en(1'b1),
    .d(sys_rst),
    .q(lnk_rst)
  );

  assign nxt_byte = {shift_ff[6:0], ser_din};
  assign byte_done = (bit_cnt_ff == BIT_LAST);
  assign nxt_target = srcd_decode(nxt_byte[ADDR_MSB:0]);
  assign lnk_target = srcd_decode(lnk_addr_ff);
  assign cmd_accept = (lnk_state_ff == LNK_CMD) && byte_done && !nxt_byte[START_BIT];
  assign wr_accept = (lnk_state_ff == LNK_DATA) && byte_done && !read_ff
    && srcd_writable(lnk_target);

  // frame state ends with chip select, not with a clock edge
  always_ff @(posedge ser_clk or posedge ser_cs_n) begin
    if (ser_cs_n) begin
      lnk_state_ff <= LNK_CMD;
      bit_cnt_ff <= 3'h0;
      shift_ff <= 8'h00;
      left_ff <= 2'h0;
      first_ff <= 1'b0;
      read_ff <= 1'b0;
    end else if (lnk_rst) begin
      lnk_state_ff <= LNK_CMD;
      bit_cnt_ff <= 3'h0;
      shift_ff <= 8'h00;
      left_ff <= 2'h0;
      first_ff <= 1'b0;
      read_ff <= 1'b0;
    end else begin
      shift_ff <= nxt_byte;
      bit_cnt_ff <= bit_cnt_ff + 3'h1;
      first_ff <= 1'b0;
      if (byte_done) begin
        case (lnk_state_ff)
          LNK_CMD: begin
            if (cmd_accept) begin
              lnk_state_ff <= LNK_DATA;
              left_ff <= srcd_len(nxt_target) - LEN_BYTE;
              read_ff <= nxt_byte[DIR_BIT];
              first_ff <= 1'b1;
            end
          end
          LNK_DATA: begin
            if (left_ff == 2'h0) begin
              lnk_state_ff <= LNK_CMD;
              read_ff <= 1'b0;
            end else begin
              left_ff <= left_ff - 2'h1;
            end
          end
          default: lnk_state_ff <= LNK_CMD;
        endcase
      end
    end
  end

  // held across frames so the core side never samples a cleared word
  always_ff @(posedge ser_clk) begin
    if (lnk_rst) begin
      lnk_addr_ff <= 6'h00;
      lnk_cmd_byte_ff <= CMD_SEL_RST;
      cmd_tgl_ff <= 1'b0;
    end else if (!ser_cs_n && cmd_accept) begin
      lnk_addr_ff <= nxt_byte[ADDR_MSB:0];
      lnk_cmd_byte_ff <= nxt_byte;
      cmd_tgl_ff <= ~cmd_tgl_ff;
    end
  end

  always_ff @(posedge ser_clk) begin
    if (lnk_rst) begin
      lnk_wr_ff <= '0;
      wr_tgl_ff <= 1'b0;
    end else if (!ser_cs_n && wr_accept) begin
      lnk_wr_ff <= '{data: nxt_byte, last: (left_ff == 2'h0)};
      wr_tgl_ff <= ~wr_tgl_ff;
    end
  end

  always_comb begin
    rd_aligned = '0;
    case (srcd_len(lnk_target))
      LEN_WORD: rd_aligned = lnk_rd_data;
      LEN_HALF: rd_aligned = {lnk_rd_data[15:0], 8'h00};
      default: rd_aligned = {lnk_rd_data[7:0], 16'h0000};
    endcase
    if (lnk_target == TGT_NONE) begin
      rd_aligned = '0;
    end
  end

  // read data leaves on falling edges so the host samples on rising ones
  always_ff @(negedge ser_clk or posedge ser_cs_n) begin
    if (ser_cs_n) begin
      dout_ff <= 1'b0;
      dout_oe_ff <= 1'b0;
      dout_sh_ff <= '0;
    end else if (lnk_rst) begin
      dout_ff <= 1'b0;
      dout_oe_ff <= 1'b0;
      dout_sh_ff <= '0;
    end else if (first_ff && read_ff) begin
      dout_ff <= rd_aligned[RD_W-1];
      dout_sh_ff <= rd_aligned[RD_W-2:0];
      dout_oe_ff <= 1'b1;
    end else if ((lnk_state_ff == LNK_DATA) && read_ff) begin
      dout_ff <= dout_sh_ff[RD_W-2];
      dout_sh_ff <= {dout_sh_ff[RD_W-3:0], 1'b0};
    end else begin
      dout_ff <= 1'b0;
      dout_oe_ff <= 1'b0;
    end
  end

  assign ser_dout = dout_ff;
  assign ser_dout_oe = dout_oe_ff;
  assign lnk_rd_addr = lnk_addr_ff;

  // ---------------- core domain (core_clk) ----------------
  logic [1:0] tgl_sync;
  logic [1:0] tgl_seen_ff;
  logic cmd_evt;
  logic wr_evt;
  logic [7:0] cmd_sel_ff;
  srcd_cmd_t cmd_out_ff;
  logic cmd_pulse_ff;
  srcd_wr_t wr_out_ff;
  logic wr_pulse_ff;
  srcd_target_t core_target;

  // toggles cross; the words they guard stay still for eight link edges
  srcd_sync #(.W(2)) u_tgl_sync (
    .clk(core_clk),
    .en(clk_en),
    .d({cmd_tgl_ff, wr_tgl_ff}),
    .q(tgl_sync)
  );

  assign cmd_evt = tgl_sync[1] ^ tgl_seen_ff[1];
  assign wr_evt = tgl_sync[0] ^ tgl_seen_ff[0];
  assign core_target = srcd_decode(lnk_cmd_byte_ff[ADDR_MSB:0]);

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      tgl_seen_ff <= 2'h0;
    end else if (clk_en) begin
      tgl_seen_ff <= tgl_sync;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cmd_sel_ff <= CMD_SEL_RST;
      cmd_out_ff <= '0;
      cmd_pulse_ff <= 1'b0;
    end else if (clk_en) begin
      cmd_pulse_ff <= cmd_evt;
      if (cmd_evt) begin
        cmd_sel_ff <= lnk_cmd_byte_ff;
        cmd_out_ff <= '{read: lnk_cmd_byte_ff[DIR_BIT], target: core_target,
          index: lnk_cmd_byte_ff[1:0], addr: lnk_cmd_byte_ff[ADDR_MSB:0]};
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      wr_out_ff <= '0;
      wr_pulse_ff <= 1'b0;
    end else if (clk_en) begin
      wr_pulse_ff <= wr_evt;
      if (wr_evt) begin
        wr_out_ff <= lnk_wr_ff;
      end
    end
  end

  assign command_selector = cmd_sel_ff;
  assign cmd_out = cmd_out_ff;
  assign cmd_pulse = cmd_pulse_ff;
  assign wr_out = wr_out_ff;
  assign wr_pulse = wr_pulse_ff;

endmodule

// ===== design/srcd_pkg.sv
// constants, types and decode helpers for the serial command decoder
package srcd_pkg;

  // command byte layout and reset value
  localparam logic [7:0] CMD_SEL_RST = 8'h00;
  localparam int START_BIT = 7;
  localparam int DIR_BIT = 6;
  localparam int ADDR_MSB = 5;
  localparam logic [2:0] BIT_LAST = 3'h7;

  // register address codes
  localparam logic [5:0] ADDR_STATUS = 6'h00;
  localparam logic [5:0] ADDR_ADC_MODE = 6'h01;
  localparam logic [5:0] ADDR_IF_MODE = 6'h02;
  localparam logic [5:0] ADDR_CHECKSUM = 6'h03;
  localparam logic [5:0] ADDR_RESULT = 6'h04;
  localparam logic [5:0] ADDR_GPIO = 6'h06;
  localparam logic [5:0] ADDR_IDENT = 6'h07;
  localparam logic [5:0] ADDR_CHAN_BASE = 6'h10;
  localparam logic [5:0] ADDR_SETUP_BASE = 6'h20;
  localparam logic [5:0] ADDR_FILT_BASE = 6'h28;
  localparam logic [5:0] ADDR_OFFS_BASE = 6'h30;
  localparam logic [5:0] ADDR_GAIN_BASE = 6'h38;
  localparam logic [5:0] BANK_MASK = 6'h3C;

  // data phase length in bytes
  localparam logic [1:0] LEN_BYTE = 2'h1;
  localparam logic [1:0] LEN_HALF = 2'h2;
  localparam logic [1:0] LEN_WORD = 2'h3;
  localparam int DATA_W = 24;

  typedef enum logic [3:0] {
    TGT_NONE = 4'h0,
    TGT_STATUS = 4'h1,
    TGT_ADC_MODE = 4'h2,
    TGT_IF_MODE = 4'h3,
    TGT_CHECKSUM = 4'h4,
    TGT_RESULT = 4'h5,
    TGT_GPIO = 4'h6,
    TGT_IDENT = 4'h7,
    TGT_CHAN = 4'h8,
    TGT_SETUP = 4'h9,
    TGT_FILT = 4'hA,
    TGT_OFFS = 4'hB,
    TGT_GAIN = 4'hC
  } srcd_target_t;

  typedef enum logic [1:0] {
    LNK_CMD = 2'b01,
    LNK_DATA = 2'b10
  } srcd_lnk_state_t;

  typedef struct packed {
    logic read;
    srcd_target_t target;
    logic [1:0] index;
    logic [5:0] addr;
  } srcd_cmd_t;

  typedef struct packed {
    logic [7:0] data;
    logic last;
  } srcd_wr_t;

  function automatic srcd_target_t srcd_decode(input logic [5:0] a);
    srcd_target_t t;
    t = TGT_NONE;
    if (a == ADDR_STATUS) begin
      t = TGT_STATUS;
    end else if (a == ADDR_ADC_MODE) begin
      t = TGT_ADC_MODE;
    end else if (a == ADDR_IF_MODE) begin
      t = TGT_IF_MODE;
    end else if (a == ADDR_CHECKSUM) begin
      t = TGT_CHECKSUM;
    end else if (a == ADDR_RESULT) begin
      t = TGT_RESULT;
    end else if (a == ADDR_GPIO) begin
      t = TGT_GPIO;
    end else if (a == ADDR_IDENT) begin
      t = TGT_IDENT;
    end else if ((a & BANK_MASK) == ADDR_CHAN_BASE) begin
      t = TGT_CHAN;
    end else if ((a & BANK_MASK) == ADDR_SETUP_BASE) begin
      t = TGT_SETUP;
    end else if ((a & BANK_MASK) == ADDR_FILT_BASE) begin
      t = TGT_FILT;
    end else if ((a & BANK_MASK) == ADDR_OFFS_BASE) begin
      t = TGT_OFFS;
    end else if ((a & BANK_MASK) == ADDR_GAIN_BASE) begin
      t = TGT_GAIN;
    end
    return t;
  endfunction

  function automatic logic [1:0] srcd_len(input srcd_target_t t);
    logic [1:0] n;
    n = LEN_HALF;
    case (t)
      TGT_NONE, TGT_STATUS: n = LEN_BYTE;
      TGT_CHECKSUM, TGT_RESULT, TGT_OFFS, TGT_GAIN: n = LEN_WORD;
      default: n = LEN_HALF;
    endcase
    return n;
  endfunction

  function automatic logic srcd_writable(input srcd_target_t t);
    logic w;
    w = 1'b1;
    case (t)
      TGT_NONE, TGT_STATUS, TGT_CHECKSUM, TGT_RESULT, TGT_IDENT: w = 1'b0;
      default: w = 1'b1;
    endcase
    return w;
  endfunction

endpackage

// ===== design/srcd_sync.sv
// two-stage synchroniser with hold enable
`timescale 1ns/1ps
module srcd_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic en,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_ff;

  always_ff @(posedge clk) begin
    if (en) begin
      meta_ff <= d;
      q <= meta_ff;
    end
  end
endmodule

// ===== bench/srcd_sva.sv
// port assertions for the command decoder
`timescale 1ns/1ps
module srcd_sva
  import srcd_pkg::*;
#(
  parameter int RD_W = DATA_W
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic ser_clk,
  input wire logic ser_cs_n,
  input wire logic ser_din,
  input wire logic ser_dout,
  input wire logic ser_dout_oe,
  input wire logic [5:0] lnk_rd_addr,
  input wire logic [RD_W-1:0] lnk_rd_data,
  input wire logic [7:0] command_selector,
  input wire srcd_cmd_t cmd_out,
  input wire logic cmd_pulse,
  input wire srcd_wr_t wr_out,
  input wire logic wr_pulse
);
  cmd_once_a: assert property (
    @(posedge core_clk) disable iff (sys_rst) cmd_pulse && clk_en |=> !cmd_pulse)
    else $error("cmd pulse too long");
  rst_zero_a: assert property (
    @(posedge core_clk) $fell(sys_rst) |-> command_selector == CMD_SEL_RST && cmd_out == '0)
    else $error("outputs not zero after reset");
  start_low_a: assert property (
    @(posedge core_clk) disable iff (sys_rst) cmd_pulse |-> !command_selector[START_BIT])
    else $error("command taken with start bit high");
  dir_bit_a: assert property (
    @(posedge core_clk) disable iff (sys_rst) cmd_pulse |-> cmd_out.read == command_selector[6])
    else $error("direction bit wrong");
  addr_field_a: assert property (
    @(posedge core_clk) disable iff (sys_rst) cmd_pulse |-> cmd_out.addr == command_selector[5:0])
    else $error("address field wrong");
  bank_index_a: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    cmd_pulse && command_selector[5] |-> cmd_out.index == command_selector[1:0])
    else $error("bank index wrong");
  sel_hold_a: assert property (
    @(posedge core_clk) disable iff (sys_rst) $changed(command_selector) |-> cmd_pulse)
    else $error("command changed without pulse");
  wr_mapped_a: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    wr_pulse |-> !cmd_out.read && cmd_out.target != TGT_NONE
      && cmd_out.target != TGT_STATUS && cmd_out.target != TGT_CHECKSUM
      && cmd_out.target != TGT_RESULT && cmd_out.target != TGT_IDENT)
    else $error("write to unmapped or read target");
  dout_idle_a: assert property (
    @(posedge ser_clk) disable iff (sys_rst) !ser_dout_oe |-> !ser_dout)
    else $error("data out moves while idle");
endmodule
bind srcd_top srcd_sva #(.RD_W(RD_W)) u_sva (.*);

// ===== bench/srcd_host.sv
// host side model of the serial port
`timescale 1ns/1ps
module srcd_host (
  output logic ser_clk,
  output logic ser_cs_n,
  output logic ser_din,
  input wire logic ser_dout
);
  initial begin
    ser_clk = 1'b0;
    ser_cs_n = 1'b1;
    ser_din = 1'b1;
  end
  // only to flush the link reset synchroniser
  task automatic idle_clk;
    repeat (4) begin
      #7.5 ser_clk = 1'b1;
      #7.5 ser_clk = 1'b0;
    end
  endtask
  task automatic frame(input logic [63:0] v, input int nb, output logic [23:0] r);
    r = 24'h0;
    ser_cs_n = 1'b0;
    for (int i = 0; i < nb; i++) begin
      ser_din = v[63-i];
      #7.5 ser_clk = 1'b1;
      r = {r[22:0], ser_dout};
      #7.5 ser_clk = 1'b0;
    end
    // released line flips so a stale bit cannot pass
    ser_din = ~ser_din;
    #7.5 ser_cs_n = 1'b1;
    #30;
  endtask
endmodule

// ===== bench/tb_top.sv
// self-checking bench for the command decoder
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fail_count++; \
  $display("ERROR t=%0t got %0h exp %0h", $time, g, e); end end
module tb_top;
  import srcd_pkg::*;
  logic core_clk, sys_rst, ser_clk, ser_cs_n, ser_din, ser_dout, ser_dout_oe;
  logic cmd_pulse, wr_pulse, clk_en;
  logic [5:0] lnk_rd_addr;
  logic [7:0] command_selector;
  logic [23:0] rd;
  srcd_cmd_t cmd_out;
  srcd_wr_t wr_out;
  srcd_wr_t wq[$];
  int fail_count = 0;
  int checks = 0;
  int ncmd = 0;
  int noe = 0;
  // bank stand-in: word made from its own address
  wire logic [23:0] bank = {2'h2, lnk_rd_addr, 2'h1, lnk_rd_addr, 2'h3, lnk_rd_addr};
  srcd_host host (.ser_clk(ser_clk), .ser_cs_n(ser_cs_n), .ser_din(ser_din),
    .ser_dout(ser_dout));
  srcd_top dut (.core_clk(core_clk), .sys_rst(sys_rst), .clk_en(clk_en), .ser_clk(ser_clk),
    .ser_cs_n(ser_cs_n), .ser_din(ser_din), .ser_dout(ser_dout), .ser_dout_oe(ser_dout_oe),
    .lnk_rd_addr(lnk_rd_addr), .lnk_rd_data(bank), .command_selector(command_selector),
    .cmd_out(cmd_out), .cmd_pulse(cmd_pulse), .wr_out(wr_out), .wr_pulse(wr_pulse));
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  always @(negedge core_clk) begin
    if (cmd_pulse === 1'b1) ncmd++;
    if (wr_pulse === 1'b1) wq.push_back(wr_out);
  end
  // rising edges that see the read driver enabled
  always @(posedge ser_clk) begin
    if (ser_dout_oe === 1'b1) noe++;
  end
  task automatic xfer(input logic [63:0] v, input int nb);
    noe = 0;
    host.frame(v, nb, rd);
    @(negedge core_clk);
  endtask
  task automatic t_read;
    logic [5:0] a [17] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h06, 6'h07, 6'h13,
      6'h20, 6'h23, 6'h28, 6'h2B, 6'h30, 6'h33, 6'h38, 6'h3B};
    srcd_target_t t [17] = '{TGT_STATUS, TGT_ADC_MODE, TGT_IF_MODE, TGT_CHECKSUM, TGT_RESULT,
      TGT_NONE, TGT_GPIO, TGT_IDENT, TGT_CHAN, TGT_SETUP, TGT_SETUP, TGT_FILT, TGT_FILT,
      TGT_OFFS, TGT_OFFS, TGT_GAIN, TGT_GAIN};
    int n [17] = '{1, 2, 2, 3, 3, 1, 2, 2, 2, 2, 2, 2, 2, 3, 3, 3, 3};
    for (int i = 0; i < 17; i++) begin
      xfer({2'b01, a[i], 56'h0}, 8 + 8 * n[i]);
      `CHK(command_selector, {2'b01, a[i]})
      `CHK(cmd_out, {1'b1, t[i], a[i][1:0], a[i]})
      `CHK(rd, t[i] == TGT_NONE ? 24'h0 : bank & ~(24'hFFFFFF << (8 * n[i])))
      `CHK(lnk_rd_addr, a[i])
      `CHK(noe, 8 * n[i])
    end
    $display("read test done");
  endtask
  task automatic t_write;
    int c0;
    c0 = ncmd;
    wq = {};
    // write two bytes then a read in the same frame
    xfer({8'h01, 16'hA005, 8'h41, 32'h0}, 48);
    `CHK(rd, {8'h00, bank[15:0]})
    `CHK(noe, 16)
    xfer({8'h07, 16'h1234, 40'h0}, 24);
    `CHK(noe, 0)
    xfer({8'h05, 8'hFF, 48'h0}, 16);
    xfer({8'hC1, 8'h47, 48'h0}, 32);
    `CHK(rd, {8'h00, bank[15:0]})
    `CHK(noe, 16)
    `CHK(ncmd, c0 + 5)
    `CHK(wq.size(), 2)
    `CHK(wq[0], {8'hA0, 1'b0})
    `CHK(wq[1], {8'h05, 1'b1})
    $display("write test done");
  endtask
  // reset at start and again mid-run, link flushed before any frame
  task automatic t_reset;
    sys_rst = 1'b1;
    host.idle_clk();
    repeat (20) @(negedge core_clk);
    sys_rst = 1'b0;
    host.idle_clk();
    @(negedge core_clk);
    `CHK(command_selector, 8'h00)
    `CHK(cmd_out, 13'h0)
    `CHK(wr_out, 9'h000)
    `CHK(lnk_rd_addr, 6'h00)
    $display("reset test done");
  endtask
  // core side frozen: command waits in the crossing until enable returns
  task automatic t_hold;
    int c0;
    c0 = ncmd;
    clk_en = 1'b0;
    xfer({8'h42, 56'h0}, 24);
    repeat (4) @(negedge core_clk);
    `CHK(ncmd, c0)
    `CHK(command_selector, 8'h00)
    `CHK(rd, {8'h00, bank[15:0]})
    `CHK(noe, 16)
    clk_en = 1'b1;
    repeat (4) @(negedge core_clk);
    `CHK(ncmd, c0 + 1)
    `CHK(command_selector, 8'h42)
    `CHK(cmd_out, {1'b1, TGT_IF_MODE, 2'h2, 6'h02})
    $display("hold test done");
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    #200000;
    fail_count++;
    complete_run();
  end
  initial begin
    clk_en = 1'b1;
    t_reset();
    t_read();
    t_write();
    t_reset();
    t_hold();
    complete_run();
  end
endmodule
